// ---- rtl/cotsr_defs.svh ----
`ifndef COTSR_DEFS_SVH
`define COTSR_DEFS_SVH

// register offsets on the serial-port register port
`define COTSR_A_CAL_STROBE   5'h04
`define COTSR_A_STATUS       5'h08
`define COTSR_A_RAW_COUNT    5'h09
`define COTSR_A_NV_IMAGE     5'h0A
`define COTSR_A_NV_PERMIT    5'h0B
`define COTSR_A_NV_BIT_ADDR  5'h0C
`define COTSR_A_NV_STROBE    5'h0D
`define COTSR_A_ST_ENABLE    5'h0E
`define COTSR_A_ST_RESULT    5'h0F

// widths
`define COTSR_AW             5
`define COTSR_DW             24

// status register fields
`define COTSR_STAT_TRIM      3:0
`define COTSR_STAT_CAL_RUN   4
`define COTSR_STAT_NV_RUN    5
`define COTSR_TRIM_MAX       4'hB

// single control bit and bit index fields of the control registers
`define COTSR_CTL_ON         0
`define COTSR_IDX            3:0

// stored image fields
`define COTSR_IMG_FINE       3:0
`define COTSR_IMG_COARSE_LO  6:4
`define COTSR_IMG_GAIN       7
`define COTSR_IMG_BYPASS     8
`define COTSR_IMG_AMP_BIAS   10:9
`define COTSR_IMG_DRV_BIAS   12:11
`define COTSR_IMG_PRG_FLAG   13
`define COTSR_IMG_COARSE_HI  14
`define COTSR_IMG_USED       14:0

// self-test result fields
`define COTSR_RES_SIG        15:0
`define COTSR_RES_RUN        16

// reset values
`define COTSR_RST_WORD       24'h000000
`define COTSR_RST_SIG        16'h0000
`define COTSR_RST_NIB        4'h0

// fuse programming pulse time, least time, rounded up to cycles
`define COTSR_CLK_PERIOD_NS  100
`define COTSR_NV_PROG_NS     1000
`define COTSR_NV_PROG_CYC    ((`COTSR_NV_PROG_NS + `COTSR_CLK_PERIOD_NS - 1) \
                              / `COTSR_CLK_PERIOD_NS)
`define COTSR_CNT_W          8

`endif

// ---- rtl/cotsr_pkg.sv ----
`include "cotsr_defs.svh"

package cotsr_pkg;

    // calibration engine sequencer, one-hot
    typedef enum logic [2:0] {
        COTSR_ENG_IDLE = 3'h1,
        COTSR_ENG_CAL  = 3'h2,
        COTSR_ENG_TEST = 3'h4
    } cotsr_eng_t;

    // fuse programming sequencer, one-hot
    typedef enum logic [2:0] {
        COTSR_NV_LOAD = 3'h1,
        COTSR_NV_IDLE = 3'h2,
        COTSR_NV_PROG = 3'h4
    } cotsr_nv_t;

    // state of the fuse programmer
    typedef struct packed {
        cotsr_nv_t                st;
        logic [15:0]              image;
        logic [`COTSR_CNT_W-1:0]  cnt;
        logic                     prog;
        logic [3:0]               addr;
    } cotsr_nv_regs_t;

    // state of the register bank
    typedef struct packed {
        cotsr_eng_t               st;
        logic [3:0]               trim;
        logic [23:0]              raw;
        logic [23:0]              corr;
        logic                     permit;
        logic [3:0]               bit_addr;
        logic                     mode_on;
        logic [15:0]              sig;
        logic [23:0]              rdata;
        logic                     cal_start;
        logic                     test_start;
        logic                     nv_start;
        logic                     use_stored;
        logic                     chip_en;
        logic [3:0]               fine;
        logic [3:0]               coarse;
        logic                     gain;
        logic                     bypass;
        logic [1:0]               amp_bias;
        logic [1:0]               drv_bias;
    } cotsr_regs_t;

endpackage

// ---- rtl/cotsr_nvm_prog.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cotsr_defs.svh"

// one-time programmable fuse image and its bit programmer
module cotsr_nvm_prog
    import cotsr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // fuse array read value, caught once after reset
    input  wire logic [15:0] fuse_state,
    // program request from the register bank
    input  wire logic        start,
    input  wire logic [3:0]  addr,
    // image and status
    output logic [15:0]      image,
    output logic             running,
    // drive to the fuse macro
    output logic             fuse_prog,
    output logic [3:0]       fuse_addr
);

    cotsr_nv_regs_t cur_ff;      // registered state
    cotsr_nv_regs_t nxt_cur;     // next state

    // sequencer: load image, then program one bit per request
    always_comb begin
        nxt_cur = cur_ff;
        unique case (cur_ff.st)
            COTSR_NV_LOAD: begin
                // the strap is read here, not under reset, so reset
                // only ever loads constants
                nxt_cur.image = fuse_state;
                nxt_cur.st    = COTSR_NV_IDLE;
            end
            COTSR_NV_IDLE: begin
                if (start) begin
                    nxt_cur.st   = COTSR_NV_PROG;
                    nxt_cur.prog = 1'b1;
                    nxt_cur.addr = addr;
                    nxt_cur.cnt  = `COTSR_CNT_W'(`COTSR_NV_PROG_CYC - 1);
                end
            end
            COTSR_NV_PROG: begin
                // hold the pulse its full length; a fuse can only go 0->1
                if (cur_ff.cnt == '0) begin
                    nxt_cur.st                = COTSR_NV_IDLE;
                    nxt_cur.prog              = 1'b0;
                    nxt_cur.image[cur_ff.addr] = 1'b1;
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 1'b1;
                end
            end
            default: begin
                nxt_cur.st   = COTSR_NV_IDLE;
                nxt_cur.prog = 1'b0;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_ff.st    <= COTSR_NV_LOAD;
            cur_ff.image <= `COTSR_RST_SIG;
            cur_ff.cnt   <= '0;
            cur_ff.prog  <= 1'b0;
            cur_ff.addr  <= `COTSR_RST_NIB;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // busy covers loading too, so no request lands before the image
    assign image     = cur_ff.image;
    assign running   = cur_ff.st != COTSR_NV_IDLE;
    assign fuse_prog = cur_ff.prog;
    assign fuse_addr = cur_ff.addr;

endmodule // cotsr_nvm_prog
`default_nettype wire

// ---- rtl/cotsr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cotsr_defs.svh"

module cotsr_regs
    import cotsr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // register port from the serial interface
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    output logic [23:0]      reg_rdata,
    // values held in earlier registers of the map
    input  wire logic        main_enable,
    input  wire logic [8:0]  meas_adjust,
    // calibration engine
    output logic             cal_start,
    output logic             selftest_start,
    output logic [23:0]      cal_count_corr,
    input  wire logic        cal_done,
    input  wire logic [23:0] cal_count_raw,
    input  wire logic [3:0]  cal_trim,
    input  wire logic        selftest_done,
    input  wire logic [15:0] selftest_sig_in,
    // fuse macro
    input  wire logic [15:0] fuse_state,
    output logic             fuse_prog,
    output logic [3:0]       fuse_addr,
    // settings taken from the stored image
    output logic             use_stored,
    output logic             chip_enable,
    output logic [3:0]       stored_fine,
    output logic [3:0]       stored_coarse,
    output logic             stored_gain_boost,
    output logic             stored_bypass,
    output logic [1:0]       stored_amp_bias,
    output logic [1:0]       stored_drv_bias
);

    cotsr_regs_t cur_ff;                 // every register of the bank
    cotsr_regs_t nxt_cur;                // next value of the bank
    logic [15:0] nv_image;               // stored fuse image
    logic        nvm_program_running_flag; // fuse programmer busy

    // keep trim codes inside the legal range of the trim field
    function automatic logic [3:0] clamp_trim(input logic [3:0] t);
        clamp_trim = (t > `COTSR_TRIM_MAX) ? `COTSR_TRIM_MAX : t;
    endfunction

    // write hit on one register offset
    function automatic logic wr_hit(input logic       wr,
                                    input logic [4:0] a,
                                    input logic [4:0] want);
        wr_hit = wr && (a == want);
    endfunction

    // fuse image and programmer
    cotsr_nvm_prog u_nvm (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .fuse_state (fuse_state),
        .start      (cur_ff.nv_start),
        .addr       (cur_ff.bit_addr),
        .image      (nv_image),
        .running    (nvm_program_running_flag),
        .fuse_prog  (fuse_prog),
        .fuse_addr  (fuse_addr)
    );

    // next state of the whole bank
    always_comb begin
        nxt_cur = cur_ff;
        // start strobes last one cycle
        nxt_cur.cal_start  = 1'b0;
        nxt_cur.test_start = 1'b0;
        nxt_cur.nv_start   = 1'b0;

        // correction is added to the counter before the engine decodes
        // it; the readout below keeps the uncorrected value
        nxt_cur.corr = cal_count_raw
                       + {{15{meas_adjust[8]}}, meas_adjust};

        // writable control registers
        if (wr_hit(reg_wr, reg_addr, `COTSR_A_NV_PERMIT)) begin
            nxt_cur.permit = reg_wdata[`COTSR_CTL_ON];
        end
        if (wr_hit(reg_wr, reg_addr, `COTSR_A_NV_BIT_ADDR)) begin
            nxt_cur.bit_addr = reg_wdata[`COTSR_IDX];
        end
        if (wr_hit(reg_wr, reg_addr, `COTSR_A_ST_ENABLE)) begin
            nxt_cur.mode_on = reg_wdata[`COTSR_CTL_ON];
        end

        // fuse strobe: ignored unless permitted and the programmer is
        // idle; the host polls the busy flag rather than queueing
        if (wr_hit(reg_wr, reg_addr, `COTSR_A_NV_STROBE) && cur_ff.permit
            && !nvm_program_running_flag && !cur_ff.nv_start) begin
            nxt_cur.nv_start = 1'b1;
        end

        // calibration engine sequencer
        unique case (cur_ff.st)
            COTSR_ENG_IDLE: begin
                // any data value starts a cycle; mode picks which
                if (wr_hit(reg_wr, reg_addr, `COTSR_A_CAL_STROBE)) begin
                    if (cur_ff.mode_on) begin
                        nxt_cur.st         = COTSR_ENG_TEST;
                        nxt_cur.test_start = 1'b1;
                    end else begin
                        nxt_cur.st        = COTSR_ENG_CAL;
                        nxt_cur.cal_start = 1'b1;
                    end
                end
            end
            COTSR_ENG_CAL: begin
                // trim only changes at the end of a full cycle
                if (cal_done && !cur_ff.cal_start) begin
                    nxt_cur.st   = COTSR_ENG_IDLE;
                    nxt_cur.trim = clamp_trim(cal_trim);
                    nxt_cur.raw  = cal_count_raw;
                end
            end
            COTSR_ENG_TEST: begin
                // signature taken only when the test ends
                if (selftest_done && !cur_ff.test_start) begin
                    nxt_cur.st  = COTSR_ENG_IDLE;
                    nxt_cur.sig = selftest_sig_in;
                end
            end
            default: begin
                nxt_cur.st = COTSR_ENG_IDLE;
            end
        endcase

        // use_stored rises only once the programmed flag is blown, while the stored fields follow the image at all times;
        // until then the main enable is held off
        nxt_cur.use_stored = nv_image[`COTSR_IMG_PRG_FLAG];
        nxt_cur.chip_en    = main_enable
                             && nv_image[`COTSR_IMG_PRG_FLAG];
        nxt_cur.fine       = nv_image[`COTSR_IMG_FINE];
        nxt_cur.coarse     = {nv_image[`COTSR_IMG_COARSE_HI],
                              nv_image[`COTSR_IMG_COARSE_LO]};
        nxt_cur.gain       = nv_image[`COTSR_IMG_GAIN];
        nxt_cur.bypass     = nv_image[`COTSR_IMG_BYPASS];
        nxt_cur.amp_bias   = nv_image[`COTSR_IMG_AMP_BIAS];
        nxt_cur.drv_bias   = nv_image[`COTSR_IMG_DRV_BIAS];

        // read mux, answer one cycle after the read strobe
        if (reg_rd) begin
            nxt_cur.rdata = `COTSR_RST_WORD;
            unique case (reg_addr)
                `COTSR_A_STATUS: begin
                    nxt_cur.rdata[`COTSR_STAT_TRIM] = cur_ff.trim;
                    nxt_cur.rdata[`COTSR_STAT_CAL_RUN] =
                        cur_ff.st == COTSR_ENG_CAL;
                    nxt_cur.rdata[`COTSR_STAT_NV_RUN] =
                    nvm_program_running_flag || cur_ff.nv_start;
                end
                `COTSR_A_RAW_COUNT: begin
                    nxt_cur.rdata = cur_ff.raw;
                end
                `COTSR_A_NV_IMAGE: begin
                    // bit 15 is reserved and reads zero
                    nxt_cur.rdata[`COTSR_IMG_USED] =
                        nv_image[`COTSR_IMG_USED];
                end
                `COTSR_A_NV_PERMIT: begin
                    nxt_cur.rdata[`COTSR_CTL_ON] = cur_ff.permit;
                end
                `COTSR_A_NV_BIT_ADDR: begin
                    nxt_cur.rdata[`COTSR_IDX] = cur_ff.bit_addr;
                end
                `COTSR_A_ST_ENABLE: begin
                    nxt_cur.rdata[`COTSR_CTL_ON] = cur_ff.mode_on;
                end
                `COTSR_A_ST_RESULT: begin
                    nxt_cur.rdata[`COTSR_RES_SIG] = cur_ff.sig;
                    nxt_cur.rdata[`COTSR_RES_RUN] =
                        cur_ff.st == COTSR_ENG_TEST;
                end
                default: begin
                    // strobes, reserved and unmapped offsets read zero
                    nxt_cur.rdata = `COTSR_RST_WORD;
                end
            endcase
        end
    end

    // bank register; no enable, updates every edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cur_ff.st         <= COTSR_ENG_IDLE;
            cur_ff.trim       <= `COTSR_RST_NIB;
            cur_ff.raw        <= `COTSR_RST_WORD;
            cur_ff.corr       <= `COTSR_RST_WORD;
            cur_ff.permit     <= 1'b0;
            cur_ff.bit_addr   <= `COTSR_RST_NIB;
            cur_ff.mode_on    <= 1'b0;
            cur_ff.sig        <= `COTSR_RST_SIG;
            cur_ff.rdata      <= `COTSR_RST_WORD;
            cur_ff.cal_start  <= 1'b0;
            cur_ff.test_start <= 1'b0;
            cur_ff.nv_start   <= 1'b0;
            cur_ff.use_stored <= 1'b0;
            cur_ff.chip_en    <= 1'b0;
            cur_ff.fine       <= `COTSR_RST_NIB;
            cur_ff.coarse     <= `COTSR_RST_NIB;
            cur_ff.gain       <= 1'b0;
            cur_ff.bypass     <= 1'b0;
            cur_ff.amp_bias   <= 2'h0;
            cur_ff.drv_bias   <= 2'h0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from the bank register
    assign reg_rdata         = cur_ff.rdata;
    assign cal_start         = cur_ff.cal_start;
    assign selftest_start    = cur_ff.test_start;
    assign cal_count_corr    = cur_ff.corr;
    assign use_stored        = cur_ff.use_stored;
    assign chip_enable       = cur_ff.chip_en;
    assign stored_fine       = cur_ff.fine;
    assign stored_coarse     = cur_ff.coarse;
    assign stored_gain_boost = cur_ff.gain;
    assign stored_bypass     = cur_ff.bypass;
    assign stored_amp_bias   = cur_ff.amp_bias;
    assign stored_drv_bias   = cur_ff.drv_bias;

endmodule // cotsr_regs
`default_nettype wire

// ---- testbench/cotsr_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// calibration engine and fuse array behind the register bank
module cotsr_engine_model #(
    parameter logic [15:0] FUSE_INIT = 16'h8123 // arbitrary image
) (
    // clock
    input  wire logic        sys_clk,
    // run requests
    input  wire logic        cal_start,
    input  wire logic        selftest_start,
    // fuse drive
    input  wire logic        fuse_prog,
    input  wire logic [3:0]  fuse_addr,
    // results set by the bench
    input  wire logic [7:0]  dly,
    input  wire logic [3:0]  trim_set,
    input  wire logic [23:0] raw_set,
    input  wire logic [15:0] sig_set,
    // answers
    output logic             cal_done,
    output logic             selftest_done,
    output logic [23:0]      cal_count_raw,
    output logic [3:0]       cal_trim,
    output logic [15:0]      selftest_sig_in,
    output logic [15:0]      fuse_state
);
    logic [7:0]  cnt_ff  = 8'h00;     // cycles left in the run
    logic        on_ff   = 1'b0;      // a run is going
    logic        kind_ff = 1'b0;      // self-test run
    logic        done_ff = 1'b0;      // finish pulse
    logic [15:0] fuse_ff = FUSE_INIT; // fuse cells

    // one run at a time, prompt or slow as dly says
    always_ff @(posedge sys_clk) begin
        done_ff <= 1'b0;
        if (cal_start || selftest_start) begin
            cnt_ff  <= dly;
            on_ff   <= 1'b1;
            kind_ff <= selftest_start;
        end else if (on_ff && cnt_ff <= 8'h01) begin
            on_ff   <= 1'b0;
            done_ff <= 1'b1;
        end else if (on_ff) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // a fuse cell blows while the pulse is high
    always_ff @(posedge sys_clk) begin
        if (fuse_prog) begin
            fuse_ff[fuse_addr] <= 1'b1;
        end
    end

    // results only hold with the done pulse; otherwise garbage
    assign cal_done        = done_ff && !kind_ff;
    assign selftest_done   = done_ff && kind_ff;
    assign cal_count_raw   = cal_done ? raw_set : ~raw_set;
    assign cal_trim        = cal_done ? trim_set : ~trim_set;
    assign selftest_sig_in = selftest_done ? sig_set : ~sig_set;
    assign fuse_state      = fuse_ff;
endmodule // cotsr_engine_model
`default_nettype wire

// ---- testbench/cotsr_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// port checker for the register bank
module cotsr_regs_monitor (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // register port
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [4:0]  reg_addr,
    input wire logic [23:0] reg_rdata,
    // live settings
    input wire logic        main_enable,
    input wire logic [8:0]  meas_adjust,
    // engine and fuse
    input wire logic        cal_start,
    input wire logic        selftest_start,
    input wire logic [23:0] cal_count_corr,
    input wire logic [23:0] cal_count_raw,
    input wire logic        fuse_prog,
    input wire logic [3:0]  fuse_addr,
    input wire logic        use_stored,
    input wire logic        chip_enable
);
    logic [4:0]  pcnt_ff;                            // pulse length
    wire  [23:0] sext = {{15{meas_adjust[8]}}, meas_adjust}; // widened

    // counts cycles of the fuse pulse; saturation not needed
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !fuse_prog) pcnt_ff <= 5'h00;
        else pcnt_ff <= pcnt_ff + 5'h01;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_cal_pulse: assert property (cal_start |=> !cal_start)
        else $error("calibration start longer than one cycle");
    a_cal_cause: assert property (cal_start |->
        $past(reg_wr) && $past(reg_addr) == 5'h04)
        else $error("calibration start without strobe write");
    a_test_cause: assert property (selftest_start |->
        $past(reg_wr) && $past(reg_addr) == 5'h04 && !cal_start)
        else $error("self-test start without strobe write");
    a_fuse_cause: assert property ($rose(fuse_prog) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == 5'h0D)
        else $error("fuse pulse without strobe write");
    a_fuse_width: assert property ($fell(fuse_prog) &&
        !$past(sys_rst) |-> pcnt_ff == 5'h0A)
        else $error("fuse pulse not ten cycles");
    a_fuse_addr: assert property (fuse_prog && $past(fuse_prog) |->
        $stable(fuse_addr))
        else $error("fuse address moved in pulse");
    a_chip_gate: assert property (!$past(sys_rst) |->
        chip_enable == ($past(main_enable) && use_stored))
        else $error("chip enable not gated by flag");
    a_corr_sum: assert property (!$past(sys_rst) |->
        cal_count_corr == $past(cal_count_raw) + $past(sext))
        else $error("corrected count wrong");
    a_rdata_hold: assert property (!$past(reg_rd) &&
        !$past(sys_rst) |-> $stable(reg_rdata))
        else $error("read data changed without read");
    a_status_shape: assert property ($past(reg_rd) &&
        $past(reg_addr) == 5'h08 |->
        reg_rdata[23:6] == 18'h0 && reg_rdata[3:0] <= 4'hB)
        else $error("status word out of shape");
    a_result_shape: assert property ($past(reg_rd) &&
        $past(reg_addr) == 5'h0F |-> reg_rdata[23:17] == 7'h00)
        else $error("self-test word out of shape");
endmodule // cotsr_regs_monitor

bind cotsr_regs cotsr_regs_monitor u_mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .main_enable(main_enable), .meas_adjust(meas_adjust),
    .cal_start(cal_start), .selftest_start(selftest_start),
    .cal_count_corr(cal_count_corr), .cal_count_raw(cal_count_raw),
    .fuse_prog(fuse_prog), .fuse_addr(fuse_addr),
    .use_stored(use_stored), .chip_enable(chip_enable)
);
`default_nettype wire

// ---- testbench/cotsr_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cotsr_defs.svh"

module cotsr_regs_test;
    logic        sys_clk = 1'b0, sys_rst = 1'b1;        // clock, reset
    logic        reg_wr = 1'b0, reg_rd = 1'b0, main_enable = 1'b0;
    logic [4:0]  reg_addr = 5'h00;                      // offset
    logic [23:0] reg_wdata = 24'h000000, raw_set = 24'h00ABCD;
    logic [8:0]  meas_adjust = 9'h000;                  // correction
    logic [7:0]  dly = 8'h14;                           // engine delay
    logic [3:0]  trim_set = 4'hE;                       // above 11
    logic [15:0] sig_set = 16'h5A3C;                    // signature
    logic [23:0] reg_rdata, cal_count_corr, cal_count_raw, rv;
    logic        cal_start, selftest_start, cal_done, selftest_done;
    logic        fuse_prog, use_stored, chip_enable, gain, byp;
    logic [3:0]  fuse_addr, cal_trim, s_fine, s_coarse;
    logic [15:0] selftest_sig_in, fuse_state;
    logic [1:0]  s_amp, s_drv;                          // stored biases
    int          error_cnt = 0, cmp_count = 0, starts = 0;

    cotsr_regs u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .main_enable(main_enable), .meas_adjust(meas_adjust),
        .cal_start(cal_start), .selftest_start(selftest_start),
        .cal_count_corr(cal_count_corr), .cal_done(cal_done),
        .cal_count_raw(cal_count_raw), .cal_trim(cal_trim),
        .selftest_done(selftest_done), .selftest_sig_in(selftest_sig_in),
        .fuse_state(fuse_state), .fuse_prog(fuse_prog),
        .fuse_addr(fuse_addr), .use_stored(use_stored),
        .chip_enable(chip_enable), .stored_fine(s_fine),
        .stored_coarse(s_coarse), .stored_gain_boost(gain),
        .stored_bypass(byp), .stored_amp_bias(s_amp),
        .stored_drv_bias(s_drv));
    cotsr_engine_model u_eng (.sys_clk(sys_clk), .cal_start(cal_start),
        .selftest_start(selftest_start), .fuse_prog(fuse_prog),
        .fuse_addr(fuse_addr), .dly(dly), .trim_set(trim_set),
        .raw_set(raw_set), .sig_set(sig_set), .cal_done(cal_done),
        .selftest_done(selftest_done), .cal_count_raw(cal_count_raw),
        .cal_trim(cal_trim), .selftest_sig_in(selftest_sig_in),
        .fuse_state(fuse_state));

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;
    // counts calibration starts seen
    always @(posedge sys_clk) if (cal_start === 1'b1) starts++;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write; a free cycle follows before the next
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // one read; word lands in rv
    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        rv = reg_rdata;
    endtask
    // bounded poll until masked busy bits clear
    task automatic poll(input logic [4:0] a, input logic [23:0] m);
        int n;
        n = 0;
        rd(a);
        while ((rv & m) !== 24'h0 && n < 60) begin
            rd(a);
            n++;
        end
        chk(rv & m, 24'h0);
    endtask

    task automatic t_reset;
        logic [4:0] za[7] = '{5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
                              5'h10, 5'h1A};
        foreach (za[i]) begin
            rd(za[i]);
            chk(rv, 24'h0);
        end
        rd(`COTSR_A_STATUS);
        chk(rv, 24'h0);
        wr(`COTSR_A_NV_IMAGE, 24'hFFFFFF); // read-only, ignored
        rd(`COTSR_A_NV_IMAGE);
        chk(rv, 24'h000123);
        chk({23'h0, chip_enable}, 24'h0);
        $display("test reset done");
    endtask

    task automatic t_cal;
        wr(`COTSR_A_CAL_STROBE, 24'h123456);
        rd(`COTSR_A_STATUS);
        chk(rv, 24'h000010);
        wr(`COTSR_A_CAL_STROBE, 24'h0); // busy, ignored
        poll(`COTSR_A_STATUS, 24'h10);
        chk(rv, 24'h00000B);
        rd(`COTSR_A_RAW_COUNT);
        chk(rv, 24'h00ABCD);
        dly      <= 8'h02;
        trim_set <= 4'h7;
        raw_set  <= 24'hFEDCBA;
        wr(`COTSR_A_CAL_STROBE, 24'h0);
        poll(`COTSR_A_STATUS, 24'h10);
        chk(rv, 24'h000007);
        rd(`COTSR_A_RAW_COUNT);
        chk(rv, 24'hFEDCBA);
        chk(24'(starts), 24'h2);
        $display("test calibration done");
    endtask

    task automatic t_test;
        dly <= 8'h14;
        wr(`COTSR_A_ST_ENABLE, 24'h1);
        rd(`COTSR_A_ST_ENABLE);
        chk(rv, 24'h1);
        wr(`COTSR_A_CAL_STROBE, 24'h0);
        rd(`COTSR_A_ST_RESULT);
        chk(rv, 24'h010000);
        poll(`COTSR_A_ST_RESULT, 24'h010000);
        chk(rv, 24'h005A3C);
        wr(`COTSR_A_ST_ENABLE, 24'h0);
        chk(24'(starts), 24'h2);
        $display("test selftest done");
    endtask

    task automatic t_fuse;
        wr(`COTSR_A_NV_STROBE, 24'h0); // no permit, ignored
        rd(`COTSR_A_NV_IMAGE);
        chk(rv, 24'h000123);
        wr(`COTSR_A_NV_PERMIT, 24'h1);
        wr(`COTSR_A_NV_BIT_ADDR, 24'h00000D);
        rd(`COTSR_A_NV_BIT_ADDR);
        chk(rv, 24'h00000D);
        wr(`COTSR_A_NV_STROBE, 24'h0);
        rd(`COTSR_A_STATUS);
        chk(rv, 24'h000027);
        poll(`COTSR_A_STATUS, 24'h20);
        rd(`COTSR_A_NV_IMAGE);
        chk(rv, 24'h002123);
        chk({8'h0, use_stored, chip_enable, s_drv, s_amp, byp, gain,
             s_coarse, s_fine}, 24'h00C223);
        main_enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({23'h0, chip_enable}, 24'h0);
        $display("test fuse done");
    endtask

    task automatic t_corr;
        logic [8:0] m[2] = '{9'h1F0, 9'h0FF};
        foreach (m[i]) begin
            meas_adjust <= m[i];
            repeat (3) @(posedge sys_clk);
            chk(cal_count_corr, cal_count_raw +
                {{15{m[i][8]}}, m[i]});
        end
        $display("test correction done");
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst     <= 1'b0;
        main_enable <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset;
        t_cal;
        t_test;
        t_fuse;
        t_corr;
        conclude;
    end

    // watchdog, well past the expected run
    initial begin
        repeat (6000) @(posedge sys_clk);
        error_cnt++;
        $display("BAD at %0t: watchdog expired", $time);
        conclude;
    end
endmodule // cotsr_regs_test
`default_nettype wire
